// File: verilog/fpg_defs.vh
`ifndef FPG_DEFS_VH
`define FPG_DEFS_VH

// ----------------------------------------------------------------------
// register indices and byte addresses (byte address = index * 4)
// ----------------------------------------------------------------------
`define FPG_IDX_CTRL      8'h8F
`define FPG_IDX_KEY       8'hB7
`define FPG_IDX_RESET_SOURCE_REGISTER    8'hEF
`define FPG_ADDR_CTRL     {22'h0, `FPG_IDX_CTRL, 2'b00}
`define FPG_ADDR_KEY      {22'h0, `FPG_IDX_KEY, 2'b00}
`define FPG_ADDR_RESET_SOURCE_REGISTER   {22'h0, `FPG_IDX_RESET_SOURCE_REGISTER, 2'b00}

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define FPG_CTRL_RESET    2'h0
`define FPG_BIT_WREN      0
`define FPG_BIT_EREN      1
`define FPG_BIT_FERR      0
`define FPG_READ_ZERO     32'h00000000
`define FPG_PAD_CTRL      30'h0
`define FPG_PAD_RST       31'h0
`define FPG_LOCK_NONE     8'hFF

// ----------------------------------------------------------------------
// key codes and key state read codes
// ----------------------------------------------------------------------
`define FPG_KEY_FIRST     8'hA5
`define FPG_KEY_SECOND    8'hF1
`define FPG_KSTAT_LOCKED  2'h0
`define FPG_KSTAT_HALF    2'h1
`define FPG_KSTAT_OPEN    2'h2
`define FPG_KSTAT_DEAD    2'h3

// ----------------------------------------------------------------------
// debug port operation codes and bus constants
// ----------------------------------------------------------------------
`define FPG_DBG_WRITE     2'h0
`define FPG_DBG_ERASE     2'h1
`define FPG_DBG_DEVERASE  2'h2
`define FPG_HTRANS_NONSEQ 2'h2
`define FPG_HTRANS_SEQ    2'h3

`endif

// File: verilog/fpg_key_fsm.v
`timescale 1ns/1ps
`include "fpg_defs.vh"

// two-code unlock sequence; a fault sticks until reset
module fpg_key_fsm (
  input  wire       clk,
  input  wire       rst_b,
  input  wire       keyWrite,
  input  wire [7:0] keyData,
  input  wire       opAttempt,
  input  wire       opDone,
  output reg  [1:0] keyState
);

  localparam [3:0] S_LOCKED = 4'h1;
  localparam [3:0] S_HALF   = 4'h2;
  localparam [3:0] S_OPEN   = 4'h4;
  localparam [3:0] S_DEAD   = 4'h8;

  reg [3:0] state_reg;
  reg [3:0] state_next;

  // ----------------------------------------------------------------------
  // sequence tracking
  // ----------------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_LOCKED: begin
        if (keyWrite)
          state_next = (keyData == `FPG_KEY_FIRST) ? S_HALF : S_DEAD;
        else if (opAttempt)
          state_next = S_DEAD;
      end
      S_HALF: begin
        if (keyWrite)
          state_next = (keyData == `FPG_KEY_SECOND) ? S_OPEN : S_DEAD;
        else if (opAttempt)
          state_next = S_DEAD;
      end
      S_OPEN: begin
        // a third key write is out of order, so it kills the key
        if (keyWrite)
          state_next = S_DEAD;
        else if (opDone)
          state_next = S_LOCKED;
      end
      S_DEAD: state_next = S_DEAD;
      default: state_next = S_DEAD;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_b)
      state_reg <= S_LOCKED;
    else
      state_reg <= state_next;
  end

  // read-back code of the lock state
  always @* begin
    case (state_reg)
      S_LOCKED: keyState = `FPG_KSTAT_LOCKED;
      S_HALF:   keyState = `FPG_KSTAT_HALF;
      S_OPEN:   keyState = `FPG_KSTAT_OPEN;
      default:  keyState = `FPG_KSTAT_DEAD;
    endcase
  end

endmodule

// File: verilog/fpg_page_guard.v
`timescale 1ns/1ps
`include "fpg_defs.vh"

// decides whether a flash address falls in a protected page
module fpg_page_guard #(
  parameter AW = 14,
  parameter PW = 9
) (
  input  wire [7:0]    lockCode,
  input  wire [AW-1:0] addr,
  input  wire [AW-1:0] lockAddr,
  output wire          pageLocked,
  output wire          onLockPage
);

  localparam PGW = AW - PW;

  wire [7:0] lockedCount;
  wire [7:0] pageNum;
  wire       anyLocked;

  // ----------------------------------------------------------------------
  // page count is the ones complement of the lock code, from page 0 up
  // ----------------------------------------------------------------------
  assign lockedCount = ~lockCode;
  assign pageNum     = {{(8-PGW){1'b0}}, addr[AW-1:PW]};
  assign anyLocked   = (lockCode != `FPG_LOCK_NONE);
  assign onLockPage  = (addr[AW-1:PW] == lockAddr[AW-1:PW]);
  // lock byte page joins the protected set once any page is locked
  assign pageLocked  = (pageNum < lockedCount) |
                       (anyLocked & onLockPage);

endmodule

// File: verilog/fpg_flash_guard.v
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "fpg_defs.vh"

// ----------------------------------------------------------------------
// flash program and erase guard
// ----------------------------------------------------------------------
// Overview of operation
// - debug device erase wipes every page
// - firmware violation forces reset, error flag set
// - debug violations are dropped without reset
// - any locked page also locks lock page
// - programmed lock byte changes only by device erase
// - new lock byte applies after next reset
// - interrupts held pending during flash operation
// - control bits seven to two read zero
// - erase enable plus write enable erases page
// - write enable steers move writes to flash
// - two ordered key codes, else disabled
// - unlock cleared after every firmware operation
// - locked pages equal ones complement lock byte
// - key read returns lock state code
module fpg_flash_guard #(
  parameter                AW       = 14,
  parameter                PW       = 9,
  parameter [AW-1:0]       LOCK_ADDR = 14'h3DFF
) (
  input  wire              clk,
  input  wire              rst_b,
  // ahb-lite slave
  input  wire              hsel,
  input  wire [31:0]       haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire              hready,
  input  wire [31:0]       hwdata,
  output reg  [31:0]       hrdata,
  output reg               hreadyout,
  output reg               hresp,
  // external-move writes from the core
  input  wire              moveWrValid,
  input  wire [AW-1:0]     moveWrAddr,
  input  wire [7:0]        moveWrData,
  input  wire              moveFromLocked,
  // two-wire debug port requests
  input  wire              dbgValid,
  input  wire [1:0]        dbgOp,
  input  wire [AW-1:0]     dbgAddr,
  input  wire [7:0]        dbgData,
  // lock byte as it stands in the array
  input  wire [7:0]        lockByteIn,
  // flash array command port
  output reg               flashCmdValid,
  output reg               flashCmdErase,
  output reg               flashCmdChipErase,
  output reg  [AW-1:0]     flashCmdAddr,
  output reg  [7:0]        flashCmdData,
  input  wire              flashDone,
  // to core and reset controller
  output reg               opBusy,
  output reg               irqHold,
  output reg               flashErrReset
);

  localparam [1:0] S_IDLE = 2'h1;
  localparam [1:0] S_BUSY = 2'h2;

  reg  [1:0]    state_reg;
  reg  [1:0]    state_next;
  reg           wrEn_reg;
  reg           erEn_reg;
  reg  [7:0]    lockActive_reg;
  // no reset: it must outlive the reset that it requests
  reg           errPending_reg = 1'b0;
  reg           errFlag_reg;
  reg           fwOp_reg;
  reg           dataPhase_reg;
  reg           dataWrite_reg;
  reg  [31:0]   dataAddr_reg;

  wire          keyWrite;
  wire [1:0]    keyState;
  wire          dbgLocked;
  wire          dbgOnLock;
  wire          fwLocked;
  wire          fwOnLock;
  wire          lockProgrammed;
  wire          fwReq;
  wire          keyOpen;
  wire          fwViolation;
  wire          dbgViolation;
  wire          addrPhase;
  wire          issueDbg;
  wire          issueFw;
  wire          fwAttempt;
  wire          opDone;
  wire [31:0]   readValue;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  // only whole-word transfers are expected, so hsize is not decoded
  assign addrPhase = hsel & hready & hwrite == 1'b0 |
                     hsel & hready & hwrite;
  wire transOk = (htrans == `FPG_HTRANS_NONSEQ) |
                 (htrans == `FPG_HTRANS_SEQ);
  assign keyWrite = dataPhase_reg & dataWrite_reg &
                    (dataAddr_reg == `FPG_ADDR_KEY);

  // read value chosen in the address phase, registered for the data phase
  assign readValue =
    (haddr == `FPG_ADDR_CTRL)   ? {`FPG_PAD_CTRL, erEn_reg, wrEn_reg} :
    (haddr == `FPG_ADDR_KEY)    ? {`FPG_PAD_CTRL, keyState} :
    (haddr == `FPG_ADDR_RESET_SOURCE_REGISTER) ? {`FPG_PAD_RST, errFlag_reg} :
    `FPG_READ_ZERO;

  // zero wait state slave, always OKAY
  always @(posedge clk) begin
    if (!rst_b) begin
      dataPhase_reg <= 1'b0;
      dataWrite_reg <= 1'b0;
      dataAddr_reg  <= `FPG_READ_ZERO;
      hrdata        <= `FPG_READ_ZERO;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (hready) begin
        dataPhase_reg <= addrPhase & transOk;
        dataWrite_reg <= hwrite;
        dataAddr_reg  <= haddr;
        if (addrPhase & transOk & !hwrite)
          hrdata <= readValue;
      end
    end
  end

  // ----------------------------------------------------------------------
  // program-store control register
  // ----------------------------------------------------------------------
  // upper bits are not stored at all, so writes there vanish
  always @(posedge clk) begin
    if (!rst_b) begin
      {erEn_reg, wrEn_reg} <= `FPG_CTRL_RESET;
    end else if (dataPhase_reg & dataWrite_reg &
                 (dataAddr_reg == `FPG_ADDR_CTRL)) begin
      wrEn_reg <= hwdata[`FPG_BIT_WREN];
      erEn_reg <= hwdata[`FPG_BIT_EREN];
    end
  end

  // ----------------------------------------------------------------------
  // key sequence and page protection
  // ----------------------------------------------------------------------
  fpg_key_fsm u_key (
    .clk       (clk),
    .rst_b     (rst_b),
    .keyWrite  (keyWrite),
    .keyData   (hwdata[7:0]),
    .opAttempt (fwAttempt),
    .opDone    (opDone & fwOp_reg),
    .keyState  (keyState)
  );

  // protection uses the copy of the lock byte taken at reset
  fpg_page_guard #(.AW(AW), .PW(PW)) u_dbg_guard (
    .lockCode   (lockActive_reg),
    .addr       (dbgAddr),
    .lockAddr   (LOCK_ADDR),
    .pageLocked (dbgLocked),
    .onLockPage (dbgOnLock)
  );

  fpg_page_guard #(.AW(AW), .PW(PW)) u_fw_guard (
    .lockCode   (lockActive_reg),
    .addr       (moveWrAddr),
    .lockAddr   (LOCK_ADDR),
    .pageLocked (fwLocked),
    .onLockPage (fwOnLock)
  );

  // a programmed lock byte refuses any change but a device erase
  assign lockProgrammed = (lockByteIn != `FPG_LOCK_NONE);
  assign keyOpen = (keyState == `FPG_KSTAT_OPEN);

  // only with write enable set does a move write target flash
  assign fwReq = moveWrValid & wrEn_reg & state_reg[0];
  assign fwAttempt = fwReq & !keyOpen;
  assign fwViolation =
    (fwLocked & !moveFromLocked) |
    (lockProgrammed & !erEn_reg & (moveWrAddr == LOCK_ADDR)) |
    (lockProgrammed & erEn_reg & fwOnLock);
  assign dbgViolation =
    dbgLocked |
    (lockProgrammed & (dbgOp == `FPG_DBG_WRITE) &
     (dbgAddr == LOCK_ADDR)) |
    (lockProgrammed & (dbgOp == `FPG_DBG_ERASE) & dbgOnLock);

  // debug requests win over the core in the same cycle
  assign issueDbg = dbgValid & state_reg[0] &
                    ((dbgOp == `FPG_DBG_DEVERASE) | !dbgViolation);
  assign issueFw  = fwReq & keyOpen & !fwViolation & !dbgValid;
  assign opDone   = state_reg[1] & flashDone;

  // ----------------------------------------------------------------------
  // operation sequencer
  // ----------------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (issueDbg | issueFw)
          state_next = S_BUSY;
      end
      S_BUSY: begin
        if (flashDone)
          state_next = S_IDLE;
      end
      default: state_next = S_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      state_reg         <= S_IDLE;
      fwOp_reg          <= 1'b0;
      flashCmdValid     <= 1'b0;
      flashCmdErase     <= 1'b0;
      flashCmdChipErase <= 1'b0;
      flashCmdAddr      <= {AW{1'b0}};
      flashCmdData      <= `FPG_LOCK_NONE;
      opBusy            <= 1'b0;
      irqHold           <= 1'b0;
    end else begin
      state_reg     <= state_next;
      flashCmdValid <= 1'b0;
      // busy covers the whole operation; interrupts wait behind it
      opBusy        <= state_next[1];
      irqHold       <= state_next[1];
      if (issueDbg) begin
        fwOp_reg          <= 1'b0;
        flashCmdValid     <= 1'b1;
        flashCmdChipErase <= (dbgOp == `FPG_DBG_DEVERASE);
        flashCmdErase     <= (dbgOp != `FPG_DBG_WRITE);
        flashCmdAddr      <= dbgAddr;
        flashCmdData      <= dbgData;
      end else if (issueFw) begin
        fwOp_reg          <= 1'b1;
        flashCmdValid     <= 1'b1;
        flashCmdChipErase <= 1'b0;
        flashCmdErase     <= erEn_reg;
        flashCmdAddr      <= moveWrAddr;
        flashCmdData      <= moveWrData;
      end
    end
  end

  // ----------------------------------------------------------------------
  // flash error reset and reset-source flag
  // ----------------------------------------------------------------------
  // the request stays up until the reset controller takes the device
  // down; pending is kept through a reset of any length, so the flag
  // loaded from it survives, and it clears at the first edge after
  always @(posedge clk) begin
    if (!rst_b) begin
      errFlag_reg    <= errPending_reg;
      flashErrReset  <= 1'b0;
      lockActive_reg <= lockByteIn;
    end else begin
      if (fwReq & keyOpen & fwViolation & !dbgValid) begin
        errPending_reg <= 1'b1;
        flashErrReset  <= 1'b1;
      end else if (!flashErrReset) begin
        errPending_reg <= 1'b0;
      end
    end
  end

endmodule

// File: test/fpg_flash_guard_assertions.sv
`timescale 1ns/1ps
`include "fpg_defs.vh"
// ----
// port checker for the flash guard
// ----
module fpg_flash_guard_assertions #(
  parameter          AW        = 14,
  parameter [AW-1:0] LOCK_ADDR = 14'h3DFF
) (
  input wire          clk,
  input wire          rst_b,
  input wire          hsel,
  input wire [31:0]   haddr,
  input wire [1:0]    htrans,
  input wire          hwrite,
  input wire          hready,
  input wire [31:0]   hrdata,
  input wire          dbgValid,
  input wire [1:0]    dbgOp,
  input wire [AW-1:0] dbgAddr,
  input wire [7:0]    lockByteIn,
  input wire          flashCmdValid,
  input wire          flashCmdErase,
  input wire          flashCmdChipErase,
  input wire          flashDone,
  input wire          opBusy,
  input wire          irqHold,
  input wire          flashErrReset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // accepted requests; debug ones count only when not busy and no error reset is requested
  wire rdCtrl = hsel && hready && htrans[1] && !hwrite &&
                haddr == `FPG_ADDR_CTRL;
  wire dbgGo = dbgValid && !opBusy && !flashErrReset;
  wire dbgLock = dbgGo && dbgOp == `FPG_DBG_WRITE &&
                 dbgAddr == LOCK_ADDR && lockByteIn != `FPG_LOCK_NONE;
  AST_CTRL_HIGH_ZERO: assert property (rdCtrl |=>
    hrdata[31:2] == 30'h0) else $error("control upper bits not zero");
  AST_ERR_STICKY: assert property (flashErrReset |=> flashErrReset)
    else $error("error reset request dropped before reset");
  AST_DBG_NO_RESET: assert property (dbgValid && !flashErrReset |=>
    !flashErrReset) else $error("debug request caused error reset");
  AST_DEV_ERASE: assert property (dbgGo && dbgOp == `FPG_DBG_DEVERASE |=>
    flashCmdValid && flashCmdErase && flashCmdChipErase)
    else $error("device erase not issued");
  AST_LOCK_BYTE_KEPT: assert property (dbgLock |=> !flashCmdValid)
    else $error("programmed lock byte altered by debug write");
  AST_IRQ_HOLD: assert property (flashCmdValid |-> opBusy && irqHold)
    else $error("interrupts not held during operation");
  AST_HOLD_UNTIL_DONE: assert property (opBusy && !flashDone |=>
    opBusy && irqHold) else $error("busy dropped before done");
  AST_CMD_ONE_SHOT: assert property ($rose(flashCmdValid) |=>
    !flashCmdValid) else $error("command longer than one cycle");
  // main scenarios reached
  cover property (dbgGo && dbgOp == `FPG_DBG_DEVERASE);
  cover property ($rose(flashErrReset));
  cover property (flashCmdValid && flashCmdErase && !flashCmdChipErase);
endmodule

bind fpg_flash_guard fpg_flash_guard_assertions #(
  .AW(AW), .LOCK_ADDR(LOCK_ADDR)
) i_fpg_flash_guard_assertions (
  .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .dbgValid(dbgValid), .dbgOp(dbgOp), .dbgAddr(dbgAddr),
  .lockByteIn(lockByteIn), .flashCmdValid(flashCmdValid),
  .flashCmdErase(flashCmdErase), .flashCmdChipErase(flashCmdChipErase),
  .flashDone(flashDone), .opBusy(opBusy), .irqHold(irqHold),
  .flashErrReset(flashErrReset)
);

// File: test/fpg_flash_model.sv
`timescale 1ns/1ps
// ----
// flash array stand-in: answers each command after a delay
// ----
module fpg_flash_model (
  input wire clk,
  input wire rst_b,
  input wire flashCmdValid,
  input wire slow,
  output reg flashDone
);
  reg [3:0] waitCnt_reg;
  reg       running_reg;
  // slow mode mimics a page erase, which takes far longer than a byte
  always @(posedge clk) begin
    flashDone <= 1'b0;
    if (!rst_b) begin
      running_reg <= 1'b0;
      waitCnt_reg <= 4'h0;
    end else if (flashCmdValid) begin
      running_reg <= 1'b1;
      waitCnt_reg <= slow ? 4'hC : 4'h1;
    end else if (running_reg) begin
      if (waitCnt_reg == 4'h0) begin
        flashDone   <= 1'b1;
        running_reg <= 1'b0;
      end else begin
        waitCnt_reg <= waitCnt_reg - 4'h1;
      end
    end
  end
endmodule

// File: test/fpg_flash_guard_tb.sv
`timescale 1ns/1ps
`include "fpg_defs.vh"
// compare and count; four-state equality so unknowns never match
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp=%0h got=%0h", n, e, g); end end

module fpg_flash_guard_tb;
  localparam [13:0] LOCK_ADDR = 14'h3DFF;
  reg         clk = 1'b0;
  reg         rst_b = 1'b0;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg         moveWrValid = 1'b0;
  reg  [13:0] moveWrAddr = 14'h0;
  reg  [7:0]  moveWrData = 8'h0;
  reg         moveFromLocked = 1'b0;
  reg         dbgValid = 1'b0;
  reg  [1:0]  dbgOp = 2'h0;
  reg  [13:0] dbgAddr = 14'h0;
  reg  [7:0]  dbgData = 8'h0;
  reg  [7:0]  lockByteIn = 8'hFF;
  reg         slow = 1'b0;
  wire [31:0] hrdata;
  wire        hreadyout, hresp, flashCmdValid, flashCmdErase;
  wire        flashCmdChipErase, flashDone, opBusy, irqHold, flashErrReset;
  wire [13:0] flashCmdAddr;
  wire [7:0]  flashCmdData;
  reg  [31:0] q;
  int         mismatches = 0;
  int         checked = 0;

  always #2 clk = ~clk;

  fpg_flash_guard i_fpg_flash_guard (
    .clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .moveWrValid(moveWrValid), .moveWrAddr(moveWrAddr),
    .moveWrData(moveWrData), .moveFromLocked(moveFromLocked),
    .dbgValid(dbgValid), .dbgOp(dbgOp), .dbgAddr(dbgAddr),
    .dbgData(dbgData), .lockByteIn(lockByteIn),
    .flashCmdValid(flashCmdValid), .flashCmdErase(flashCmdErase),
    .flashCmdChipErase(flashCmdChipErase), .flashCmdAddr(flashCmdAddr),
    .flashCmdData(flashCmdData), .flashDone(flashDone), .opBusy(opBusy),
    .irqHold(irqHold), .flashErrReset(flashErrReset));
  fpg_flash_model i_fpg_flash_model (.clk(clk), .rst_b(rst_b),
    .flashCmdValid(flashCmdValid), .slow(slow), .flashDone(flashDone));

  // ----
  // bus and request helpers
  // ----
  task end_sim;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // a bounded wait for hready; running out ends the run
  task waitRdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      mismatches++;
      end_sim;
    end
  endtask
  task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= `FPG_HTRANS_NONSEQ;
    haddr  <= a;
    hwrite <= w;
    waitRdy;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy;
    q = hrdata;
  endtask
  task rd(input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    `CHK("read", e, q)
    `CHK("hresp", 1'b0, hresp)
  endtask
  task unlock;
    ahb(1'b1, `FPG_ADDR_KEY, {24'h0, `FPG_KEY_FIRST});
    ahb(1'b1, `FPG_ADDR_KEY, {24'h0, `FPG_KEY_SECOND});
  endtask
  // each request is a one-cycle pulse; return lands in the answer cycle
  task core(input logic [13:0] a, input logic [7:0] d);
    moveWrValid <= 1'b1;
    moveWrAddr  <= a;
    moveWrData  <= d;
    @(posedge clk);
    moveWrValid <= 1'b0;
    @(posedge clk);
  endtask
  task dbg(input logic [1:0] op, input logic [13:0] a);
    dbgValid <= 1'b1;
    dbgOp    <= op;
    dbgAddr  <= a;
    dbgData  <= 8'h5A;
    @(posedge clk);
    dbgValid <= 1'b0;
    @(posedge clk);
  endtask
  // judge the command cycle, then wait out the operation
  task expCmd(input logic v, input logic er, input logic ch,
              input logic [13:0] a);
    int n;
    `CHK("cmdValid", v, flashCmdValid)
    if (v) begin
      `CHK("cmdErase", er, flashCmdErase)
      `CHK("chipErase", ch, flashCmdChipErase)
      `CHK("cmdAddr", a, flashCmdAddr)
      `CHK("irqHold", 1'b1, irqHold)
    end
    n = 0;
    while (opBusy !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    `CHK("opBusy", 1'b0, opBusy)
    if (opBusy !== 1'b0)
      end_sim;
  endtask
  task doReset;
    rst_b <= 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
  endtask

  // ----
  // scenarios
  // ----
  task s_regs;
    rd(`FPG_ADDR_CTRL, 32'h0);
    ahb(1'b1, `FPG_ADDR_CTRL, 32'hFFFFFFFF);
    rd(`FPG_ADDR_CTRL, 32'h3);
    ahb(1'b1, `FPG_ADDR_RESET_SOURCE_REGISTER, 32'hFFFFFFFF);
    rd(`FPG_ADDR_RESET_SOURCE_REGISTER, 32'h0);
    ahb(1'b1, 32'h00000100, 32'hFFFFFFFF);
    rd(32'h00000100, 32'h0);
  endtask
  task s_write;
    ahb(1'b1, `FPG_ADDR_CTRL, 32'h1);
    rd(`FPG_ADDR_KEY, 32'h0);
    ahb(1'b1, `FPG_ADDR_KEY, {24'h0, `FPG_KEY_FIRST});
    rd(`FPG_ADDR_KEY, 32'h1);
    ahb(1'b1, `FPG_ADDR_KEY, {24'h0, `FPG_KEY_SECOND});
    rd(`FPG_ADDR_KEY, 32'h2);
    core(14'h0A05, 8'h3C);
    `CHK("cmdData", 8'h3C, flashCmdData)
    expCmd(1'b1, 1'b0, 1'b0, 14'h0A05);
    rd(`FPG_ADDR_KEY, 32'h0);
  endtask
  task s_erase;
    slow <= 1'b1;
    // interrupts, clock source and supply monitor stay outside the bench
    ahb(1'b1, `FPG_ADDR_CTRL, 32'h3);
    unlock;
    core(14'h0BFF, 8'h00);
    expCmd(1'b1, 1'b1, 1'b0, 14'h0BFF);
    slow <= 1'b0;
  endtask
  // write enable off leaves the key alone; a stray key code kills it
  task s_blocked;
    ahb(1'b1, `FPG_ADDR_CTRL, 32'h0);
    unlock;
    core(14'h0C00, 8'h11);
    expCmd(1'b0, 1'b0, 1'b0, 14'h0);
    rd(`FPG_ADDR_KEY, 32'h2);
    ahb(1'b1, `FPG_ADDR_KEY, 32'h0);
    rd(`FPG_ADDR_KEY, 32'h3);
    ahb(1'b1, `FPG_ADDR_CTRL, 32'h1);
    core(14'h0C00, 8'h11);
    expCmd(1'b0, 1'b0, 1'b0, 14'h0);
  endtask
  task s_lock;
    doReset;
    lockByteIn <= 8'hFD;
    ahb(1'b1, `FPG_ADDR_CTRL, 32'h1);
    unlock;
    core(14'h0010, 8'h22);
    expCmd(1'b1, 1'b0, 1'b0, 14'h0010);
    doReset;
    ahb(1'b1, `FPG_ADDR_CTRL, 32'h1);
    unlock;
    moveFromLocked <= 1'b1;
    core(14'h0010, 8'h22);
    expCmd(1'b1, 1'b0, 1'b0, 14'h0010);
    moveFromLocked <= 1'b0;
    unlock;
    core(14'h0200, 8'h33);
    `CHK("errReset", 1'b1, flashErrReset)
    expCmd(1'b0, 1'b0, 1'b0, 14'h0);
    doReset;
    rd(`FPG_ADDR_RESET_SOURCE_REGISTER, 32'h1);
    dbg(`FPG_DBG_WRITE, 14'h0200);
    `CHK("errReset", 1'b0, flashErrReset)
    expCmd(1'b0, 1'b0, 1'b0, 14'h0);
    dbg(`FPG_DBG_ERASE, 14'h0400);
    expCmd(1'b1, 1'b1, 1'b0, 14'h0400);
    dbg(`FPG_DBG_WRITE, LOCK_ADDR);
    expCmd(1'b0, 1'b0, 1'b0, 14'h0);
    dbg(`FPG_DBG_DEVERASE, 14'h0000);
    expCmd(1'b1, 1'b1, 1'b1, 14'h0000);
  endtask

  // main sequence
  initial begin
    doReset;
    s_regs;
    // page of the programmed byte is erased first
    s_erase;
    s_write;
    s_blocked;
    s_lock;
    end_sim;
  end
endmodule
